// [mps_cfg.svh]
/*
 * Constants of the modem power sequencer: timing counts and counter width.
 * Assumes a 20 MHz core clock and inclusion by the sequencer files only.
 */
// What this block does
// RULE1: Host applies rail, then raises power request.
// RULE2: Command shutdown completes only after request drops.
// RULE3: Internal supply detect plus delay resets processor.
// RULE4: External reset holds; boot starts after release.
// RULE5: Boot pulses CTS on then off.
// RULE6: After init, enable interfaces and assert DSR.
// RULE7: CTS asserts after command interface initialises.
// RULE8: DCD asserts after network registration acknowledge.
// RULE9: Request drop: deregister, drop DCD, save, drop DSR.
// RULE10: Host keeps rail up to ten seconds.
// RULE11: Battery indicator pulses fast during shutdown.
// RULE12: After deregistration, radio power control switches off.
// RULE13: After shutdown, settings survive; may stay powered.
// RULE14: Reset after shutdown gives cold start, flushes settings.
// RULE15: Clock alarm wakes modem, which re-registers; code registers only while host request is high.
// RULE16: Request drop detaches then near-zero power.
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MPS_CLK_HZ          20000000
`define MPS_RST_DELAY_US    100
`define MPS_RST_DELAY_CYC   ((`MPS_RST_DELAY_US * 20) > 0 ? (`MPS_RST_DELAY_US * 20) : 1)
`define MPS_CTS_PULSE_US    10
`define MPS_CTS_PULSE_CYC   ((`MPS_CTS_PULSE_US * 20) > 0 ? (`MPS_CTS_PULSE_US * 20) : 1)
`define MPS_BLINK_MS        50
`define MPS_BLINK_CYC       (`MPS_BLINK_MS * 20000)
`define MPS_CNT_W           24

`endif

// [mps_pkg.sv]
/*
 * Types of the modem power sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mps_pkg;

    typedef enum logic [3:0] {
        MPS_OFF,
        MPS_RESET_DLY,
        MPS_BOOT_CTS,
        MPS_INIT,
        MPS_HOST_INIT,
        MPS_REGISTER,
        MPS_ONLINE,
        MPS_DEREG,
        MPS_SAVE,
        MPS_DONE
    } mps_state_t;

endpackage

// [mps_sync.sv]
/*
 * Two-flop synchroniser for pin inputs, one per bit.
 * Assumes the inputs are asynchronous to clk_i.
 */
module mps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule

// [mps_seq.sv]
/*
 * Power-on, reset and soft-shutdown sequencer of the radio modem.
 * Assumes firmware handshakes (init done, network ack, save done) arrive
 * as levels or pulses on clk_i; supply, request and reset pins from the host pass a synchroniser, the command pin does not.
 */
`include "mps_cfg.svh"

module mps_seq #(
    parameter int RST_DELAY_CYC = `MPS_RST_DELAY_CYC,
    parameter int CTS_PULSE_CYC = `MPS_CTS_PULSE_CYC,
    parameter int BLINK_CYC     = `MPS_BLINK_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Host pins
    input  wire logic supply_ok_i,
    input  wire logic host_power_request_i,
    input  wire logic host_reset_input_n_i,
    input  wire logic host_shutdown_cmd_i,
    // Firmware and radio handshakes
    input  wire logic init_ok_i,
    input  wire logic host_if_ok_i,
    input  wire logic net_reg_ack_i,
    input  wire logic dereg_done_i,
    input  wire logic save_done_i,
    input  wire logic rtc_alarm_i,
    // Status lines to host
    output logic      dsr_o,
    output logic      cts_o,
    output logic      dcd_o,
    output logic      batt_led_o,
    // Internal controls
    output logic      cpu_reset_n_o,
    output logic      if_enable_o,
    output logic      radio_power_o,
    output logic      settings_valid_o,
    output logic      save_strobe_o,
    output logic      shutdown_pending_o
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic       supply_s;
    logic       preq_s;
    logic       hrst_n_s;

    mps_sync #(
        .W (3)
    ) u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .d_i       ({supply_ok_i, host_power_request_i, host_reset_input_n_i}),
        .q_o       (pins_s)
    );

    assign supply_s = pins_s[2];
    assign preq_s   = pins_s[1];
    assign hrst_n_s = pins_s[0];

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    mps_pkg::mps_state_t            state_r;
    mps_pkg::mps_state_t            state_nxt;
    logic [`MPS_CNT_W-1:0]          cnt_r;
    logic [`MPS_CNT_W-1:0]          cnt_nxt;
    logic [`MPS_CNT_W-1:0]          blink_r;
    logic [`MPS_CNT_W-1:0]          blink_nxt;
    logic                           dsr_r;
    logic                           dsr_nxt;
    logic                           cts_r;
    logic                           cts_nxt;
    logic                           dcd_r;
    logic                           dcd_nxt;
    logic                           led_r;
    logic                           led_nxt;
    logic                           cpu_rst_n_r;
    logic                           cpu_rst_n_nxt;
    logic                           if_en_r;
    logic                           if_en_nxt;
    logic                           radio_r;
    logic                           radio_nxt;
    logic                           saved_r;
    logic                           saved_nxt;
    logic                           save_stb_r;
    logic                           save_stb_nxt;
    logic                           cmd_pend_r;
    logic                           cmd_pend_nxt;

    always_comb begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        blink_nxt     = blink_r;
        dsr_nxt       = dsr_r;
        cts_nxt       = cts_r;
        dcd_nxt       = dcd_r;
        led_nxt       = 1'b0;
        cpu_rst_n_nxt = cpu_rst_n_r;
        if_en_nxt     = if_en_r;
        radio_nxt     = radio_r;
        saved_nxt     = saved_r;
        save_stb_nxt  = 1'b0;
        cmd_pend_nxt  = cmd_pend_r | host_shutdown_cmd_i;

        // RULE3: Supply loss resets.
        if (!supply_s) begin
            state_nxt     = mps_pkg::MPS_OFF;
            cnt_nxt       = '0;
            dsr_nxt       = 1'b0;
            cts_nxt       = 1'b0;
            dcd_nxt       = 1'b0;
            cpu_rst_n_nxt = 1'b0;
            if_en_nxt     = 1'b0;
            radio_nxt     = 1'b0;
            cmd_pend_nxt  = 1'b0;
        // RULE4: External reset holds.
        end else if (!hrst_n_s) begin
            state_nxt     = mps_pkg::MPS_RESET_DLY;
            cnt_nxt       = '0;
            dsr_nxt       = 1'b0;
            cts_nxt       = 1'b0;
            dcd_nxt       = 1'b0;
            cpu_rst_n_nxt = 1'b0;
            if_en_nxt     = 1'b0;
            radio_nxt     = 1'b0;
            cmd_pend_nxt  = 1'b0;
            // RULE14: Cold start flush.
            saved_nxt     = 1'b0;
        end else begin
            unique case (state_r)
                mps_pkg::MPS_OFF: begin
                    // RULE1: Request starts power-up.
                    // RULE15: Alarm wakes modem.
                    if (preq_s || rtc_alarm_i) begin
                        state_nxt = mps_pkg::MPS_RESET_DLY;
                        cnt_nxt   = '0;
                    end
                end
                mps_pkg::MPS_RESET_DLY: begin
                    // RULE3: Reset delay counter.
                    if (cnt_r >= `MPS_CNT_W'(RST_DELAY_CYC - 1)) begin
                        cpu_rst_n_nxt = 1'b1;
                        radio_nxt     = 1'b1;
                        cts_nxt       = 1'b1;
                        cnt_nxt       = '0;
                        state_nxt     = mps_pkg::MPS_BOOT_CTS;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                mps_pkg::MPS_BOOT_CTS: begin
                    // RULE5: Boot CTS pulse.
                    if (cnt_r >= `MPS_CNT_W'(CTS_PULSE_CYC - 1)) begin
                        cts_nxt   = 1'b0;
                        state_nxt = mps_pkg::MPS_INIT;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                mps_pkg::MPS_INIT: begin
                    // RULE6: Interfaces and DSR.
                    if (init_ok_i) begin
                        if_en_nxt = 1'b1;
                        dsr_nxt   = 1'b1;
                        state_nxt = mps_pkg::MPS_HOST_INIT;
                    end
                end
                mps_pkg::MPS_HOST_INIT: begin
                    // RULE7: CTS after host interface.
                    if (host_if_ok_i) begin
                        cts_nxt   = 1'b1;
                        state_nxt = mps_pkg::MPS_REGISTER;
                    end
                end
                mps_pkg::MPS_REGISTER: begin
                    // RULE8: DCD on network ack.
                    if (!preq_s) begin
                        state_nxt = mps_pkg::MPS_DEREG;
                    end else if (net_reg_ack_i) begin
                        dcd_nxt   = 1'b1;
                        state_nxt = mps_pkg::MPS_ONLINE;
                    end
                end
                mps_pkg::MPS_ONLINE: begin
                    // RULE2: Command waits for request drop.
                    if (!preq_s) begin
                        state_nxt = mps_pkg::MPS_DEREG;
                    end
                end
                mps_pkg::MPS_DEREG: begin
                    // RULE9: Deregister then drop DCD.
                    if (dereg_done_i) begin
                        dcd_nxt      = 1'b0;
                        cts_nxt      = 1'b0;
                        // RULE12: Radio power off.
                        radio_nxt    = 1'b0;
                        save_stb_nxt = 1'b1;
                        state_nxt    = mps_pkg::MPS_SAVE;
                    end
                end
                mps_pkg::MPS_SAVE: begin
                    // RULE9: Save then drop DSR.
                    if (save_done_i) begin
                        saved_nxt    = 1'b1;
                        dsr_nxt      = 1'b0;
                        if_en_nxt    = 1'b0;
                        cmd_pend_nxt = host_shutdown_cmd_i;
                        state_nxt    = mps_pkg::MPS_DONE;
                    end
                end
                mps_pkg::MPS_DONE: begin
                    // RULE13: Idle, settings kept.
                    if (preq_s || rtc_alarm_i) begin
                        state_nxt     = mps_pkg::MPS_RESET_DLY;
                        cnt_nxt       = '0;
                        cpu_rst_n_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = mps_pkg::MPS_OFF;
                end
            endcase
        end

        // RULE11: Fast battery blink.
        if (state_r == mps_pkg::MPS_DEREG || state_r == mps_pkg::MPS_SAVE) begin
            if (blink_r >= `MPS_CNT_W'(BLINK_CYC - 1)) begin
                blink_nxt = '0;
                led_nxt   = ~led_r;
            end else begin
                blink_nxt = blink_r + 1'b1;
                led_nxt   = led_r;
            end
        end else begin
            blink_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r     <= mps_pkg::MPS_OFF;
            cnt_r       <= '0;
            blink_r     <= '0;
            dsr_r       <= 1'b0;
            cts_r       <= 1'b0;
            dcd_r       <= 1'b0;
            led_r       <= 1'b0;
            cpu_rst_n_r <= 1'b0;
            if_en_r     <= 1'b0;
            radio_r     <= 1'b0;
            saved_r     <= 1'b0;
            save_stb_r  <= 1'b0;
            cmd_pend_r  <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            blink_r     <= blink_nxt;
            dsr_r       <= dsr_nxt;
            cts_r       <= cts_nxt;
            dcd_r       <= dcd_nxt;
            led_r       <= led_nxt;
            cpu_rst_n_r <= cpu_rst_n_nxt;
            if_en_r     <= if_en_nxt;
            radio_r     <= radio_nxt;
            saved_r     <= saved_nxt;
            save_stb_r  <= save_stb_nxt;
            cmd_pend_r  <= cmd_pend_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The command only arms shutdown; the host must still drop its request.
    assign dsr_o              = dsr_r;
    assign cts_o              = cts_r;
    assign dcd_o              = dcd_r;
    assign batt_led_o         = led_r;
    assign cpu_reset_n_o      = cpu_rst_n_r;
    assign if_enable_o        = if_en_r;
    assign radio_power_o      = radio_r;
    assign settings_valid_o   = saved_r;
    assign save_strobe_o      = save_stb_r;
    assign shutdown_pending_o = cmd_pend_r;

endmodule

// [mps_chk.sv]
/*
 * Port checker of the modem power sequencer.
 * Assumes it is bound to mps_seq and shares its single clock.
 */
module mps_chk #(
    parameter int RST_DELAY_CYC = 4,
    parameter int CTS_PULSE_CYC = 2,
    parameter int BLINK_CYC     = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Host pins and handshakes
    input wire logic supply_ok_i,
    input wire logic host_power_request_i,
    input wire logic host_reset_input_n_i,
    input wire logic init_ok_i,
    input wire logic host_if_ok_i,
    input wire logic net_reg_ack_i,
    input wire logic dereg_done_i,
    input wire logic save_done_i,
    // Outputs
    input wire logic dsr_o,
    input wire logic cts_o,
    input wire logic dcd_o,
    input wire logic batt_led_o,
    input wire logic cpu_reset_n_o,
    input wire logic if_enable_o,
    input wire logic radio_power_o,
    input wire logic settings_valid_o,
    input wire logic save_strobe_o
);
    logic [7:0] pulse_cnt_r;
    logic [7:0] pulse_cnt_nxt;

    // Counts the boot pulse; a mid-pulse power loss would also end it short.
    always_comb pulse_cnt_nxt = (cts_o && !dsr_o) ? pulse_cnt_r + 8'h01 : 8'h00;
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i) pulse_cnt_r <= 8'h00;
        else pulse_cnt_r <= pulse_cnt_nxt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_BOOT_PULSE_LEN: assert property (
        $fell(cts_o) && !dsr_o |-> pulse_cnt_r == 8'(CTS_PULSE_CYC)) else $error("boot pulse length");
    AST_BOOT_START: assert property (
        $rose(cpu_reset_n_o) |-> cts_o && !dsr_o && radio_power_o) else $error("boot start");
    AST_RESET_RELEASED: assert property (
        $rose(cpu_reset_n_o) |-> $past(host_reset_input_n_i, 4) && supply_ok_i)
        else $error("boot under reset");
    AST_DSR_AFTER_INIT: assert property (
        $rose(dsr_o) |-> $past(init_ok_i) && if_enable_o && cpu_reset_n_o) else $error("dsr early");
    AST_CTS_AFTER_HOSTIF: assert property (
        $rose(cts_o) && dsr_o |-> $past(host_if_ok_i)) else $error("cts early");
    AST_DCD_AFTER_ACK: assert property (
        $rose(dcd_o) |-> $past(net_reg_ack_i) && dsr_o && cts_o) else $error("dcd early");
    AST_DSR_LAST: assert property (
        $fell(dsr_o) && supply_ok_i && host_reset_input_n_i |-> !dcd_o && $past(save_done_i)
        && settings_valid_o) else $error("dsr drop order");
    AST_SAVE_STROBE: assert property (
        save_strobe_o |-> !dcd_o ##1 !save_strobe_o) else $error("save strobe");
    AST_RADIO_OFF: assert property (
        $fell(radio_power_o) && supply_ok_i && host_reset_input_n_i |-> $past(dereg_done_i)
        && !dcd_o) else $error("radio off early");
    AST_BLINK_SHUTDOWN: assert property (
        $changed(batt_led_o) |-> !host_power_request_i) else $error("led outside shutdown");
    AST_COLD_START: assert property (
        $fell(settings_valid_o) |-> !host_reset_input_n_i) else $error("settings lost");
endmodule

bind mps_seq mps_chk #(
    .RST_DELAY_CYC(RST_DELAY_CYC), .CTS_PULSE_CYC(CTS_PULSE_CYC), .BLINK_CYC(BLINK_CYC)
) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_ok_i(supply_ok_i),
    .host_power_request_i(host_power_request_i), .host_reset_input_n_i(host_reset_input_n_i),
    .init_ok_i(init_ok_i), .host_if_ok_i(host_if_ok_i), .net_reg_ack_i(net_reg_ack_i),
    .dereg_done_i(dereg_done_i), .save_done_i(save_done_i), .dsr_o(dsr_o), .cts_o(cts_o),
    .dcd_o(dcd_o), .batt_led_o(batt_led_o), .cpu_reset_n_o(cpu_reset_n_o),
    .if_enable_o(if_enable_o), .radio_power_o(radio_power_o),
    .settings_valid_o(settings_valid_o), .save_strobe_o(save_strobe_o)
);

// [mps_host_model.sv]
/*
 * Host terminal model: drives rail, power request, reset and command.
 * Assumes the bench states its wishes on the rising clock edge.
 */
module mps_host_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Wishes of the bench
    input  wire logic rail_i,
    input  wire logic want_on_i,
    input  wire logic want_reset_i,
    input  wire logic send_cmd_i,
    input  wire logic comply_i,
    // Modem status
    input  wire logic dsr_i,
    // Host pins
    output logic      supply_ok_o,
    output logic      host_power_request_o,
    output logic      host_reset_input_n_o,
    output logic      host_shutdown_cmd_o
);
    logic cmd_sent_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            supply_ok_o <= 1'b0;
            host_power_request_o <= 1'b0;
            host_reset_input_n_o <= 1'b1;
            host_shutdown_cmd_o <= 1'b0;
            cmd_sent_r <= 1'b0;
        end else begin
            supply_ok_o <= rail_i || (supply_ok_o && dsr_i);
            host_power_request_o <= want_on_i && supply_ok_o && !(cmd_sent_r && comply_i);
            host_reset_input_n_o <= !want_reset_i;
            host_shutdown_cmd_o <= send_cmd_i;
            cmd_sent_r <= want_on_i && (cmd_sent_r || send_cmd_i);
        end
    end
endmodule

// [tb.sv]
/*
 * Testbench of the modem power sequencer.
 * Assumes the host model drives the pins and the bench plays firmware.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        rail = 1'b0, want_on = 1'b0, want_rst = 1'b0, send_cmd = 1'b0, comply = 1'b0;
    logic        init_ok = 1'b0, host_if_ok = 1'b0, net_ack = 1'b0, alarm = 1'b0;
    logic        dereg_done = 1'b0, save_done = 1'b0;
    logic        supply_ok, power_req, rst_pin_n, shut_cmd, dsr, cts, dcd, led, prev;
    logic        cpu_rst_n, if_en, radio, sv, save_stb, pending;
    int          num_errors = 0;
    int          tests_run = 0;
    int          toggles;
    // Upper byte: rail, on, reset, init, host if, ack, dereg, save.
    // Lower bits: dsr, cts, dcd, radio, settings.
    logic [15:0] rows [11] = '{16'hC002, 16'hD012, 16'hD81A, 16'hDC1E, 16'h9C1E, 16'h9E10,
                               16'h9F01, 16'h0001, 16'hC003, 16'hE000, 16'hC002};

    always #25 clk_i = ~clk_i;

    mps_host_model u_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .rail_i(rail),
        .want_on_i(want_on), .want_reset_i(want_rst), .send_cmd_i(send_cmd), .comply_i(comply),
        .dsr_i(dsr), .supply_ok_o(supply_ok), .host_power_request_o(power_req),
        .host_reset_input_n_o(rst_pin_n), .host_shutdown_cmd_o(shut_cmd));

    mps_seq #(.RST_DELAY_CYC(4), .CTS_PULSE_CYC(2), .BLINK_CYC(4)) u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_ok_i(supply_ok),
        .host_power_request_i(power_req), .host_reset_input_n_i(rst_pin_n),
        .host_shutdown_cmd_i(shut_cmd), .init_ok_i(init_ok), .host_if_ok_i(host_if_ok),
        .net_reg_ack_i(net_ack), .dereg_done_i(dereg_done), .save_done_i(save_done),
        .rtc_alarm_i(alarm), .dsr_o(dsr), .cts_o(cts), .dcd_o(dcd), .batt_led_o(led),
        .cpu_reset_n_o(cpu_rst_n), .if_enable_o(if_en), .radio_power_o(radio),
        .settings_valid_o(sv), .save_strobe_o(save_stb), .shutdown_pending_o(pending));

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic check(input logic [4:0] got, input logic [4:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic apply(input logic [7:0] v);
        @(posedge clk_i);
        {rail, want_on, want_rst, init_ok, host_if_ok, net_ack, dereg_done, save_done} <= v;
    endtask

    task automatic settle_check(input logic [4:0] exp);
        step(20);
        @(negedge clk_i);
        check({dsr, cts, dcd, radio, sv}, exp);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run needs about 400 cycles; a hang is cut off well after that.
    initial begin
        step(1500);
        num_errors++;
        print_verdict();
    end

    initial begin
        step(3);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            apply(rows[i][15:8]);
            settle_check(rows[i][4:0]);
            $display("row %0d done", i);
        end
        apply(8'hDC);
        step(20);
        send_cmd <= 1'b1;
        step(1);
        send_cmd <= 1'b0;
        step(20);
        @(negedge clk_i);
        check({dsr, cts, dcd, radio, pending}, 5'h1F);
        check({cpu_rst_n, if_en, save_stb, 2'b00}, 5'h18);
        @(posedge clk_i);
        comply <= 1'b1;
        toggles = 0;
        prev = led;
        repeat (20) begin
            @(negedge clk_i);
            if (led !== prev) toggles++;
            prev = led;
        end
        check({dsr, dcd, toggles > 1, 2'b00}, 5'h1C);
        apply(8'hDF);
        settle_check(5'h01);
        $display("command shutdown test done");
        apply(8'h80);
        alarm <= 1'b1;
        settle_check(5'h03);
        apply(8'hC0);
        alarm <= 1'b0;
        settle_check(5'h03);
        apply(8'hDC);
        settle_check(5'h1F);
        $display("alarm wake test done");
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        step(2);
        @(negedge clk_i);
        check({dsr, cts, dcd, radio, sv}, 5'h00);
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        settle_check(5'h1E);
        $display("power detect reset test done");
        print_verdict();
    end
endmodule
